// [testbench/tb.sv]
// Self-checking bench for the port-adjust command handler
`include "wpa_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb
    import wpa_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic                   i_clock;
    logic                   i_reset_n;
    wpa_byte_t              i_byte;
    logic                   i_ack_rise;
    logic                   o_byte_ack;
    logic                   o_ptr_load;
    logic [7:0]             o_ptr_code;
    logic                   busy;
    logic                   dev_rst;
    wpa_timing_t            o_timing;
    wpa_codes_t             o_codes;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [`WPA_ADDR_W-1:0] paddr;
    logic [31:0]            pwdata;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            rd;
    logic                   err;
    logic                   ea;
    wpa_codes_t             ec;
    wpa_codes_t             model;
    wpa_codes_t             defs;
    logic                   exp_ack[$];
    wpa_codes_t             exp_q[$];
    int                     bad_count;
    int                     samples_checked;

    wpa_host_model host (.i_clock(i_clock), .o_byte(i_byte), .o_ack_rise(i_ack_rise));

    wpa_port_adjust uut (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_byte(i_byte),
        .i_ack_rise(i_ack_rise),
        .o_byte_ack(o_byte_ack),
        .o_ptr_load(o_ptr_load),
        .o_ptr_code(o_ptr_code),
        .i_wire_busy_flag(busy),
        .i_device_reset(dev_rst),
        .o_timing(o_timing),
        .o_codes(o_codes),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr)
    );

    // 200 MHz clock
    initial i_clock = 1'b0;
    always #2.5 i_clock = ~i_clock;

    // Expected code store after one accepted control byte
    function automatic wpa_codes_t upd(input wpa_codes_t c, input logic [7:0] b);
        case (b[7:5])
            3'h0: if (b[4]) c.rstl_od = b[3:0]; else c.rstl_std = b[3:0];
            3'h1: if (b[4]) c.msp_od = b[3:0]; else c.msp_std = b[3:0];
            3'h2: if (b[4]) c.wol_od = b[3:0]; else c.wol_std = b[3:0];
            3'h3: c.rec0 = b[3:0];
            3'h4: c.wpu = b[3:0];
            default: ;
        endcase
        return c;
    endfunction : upd

    // Expected setting in ns or ohms for one select, speed and code
    function automatic logic [19:0] tv(input int s, input logic od, input logic [3:0] c);
        int k;
        int v;
        int lo;
        int hi;
        k  = int'(c);
        lo = 0;
        hi = 1000000;
        case (s)
            0: v = od ? 44000 + 2000 * k : 440000 + 20000 * k;
            1: begin
                v  = od ? 5000 + 500 * k : 56000 + 2000 * k;
                lo = od ? 5500 : 58000;
                hi = od ? 11000 : 76000;
            end
            2: begin
                v  = od ? 5000 + 500 * k : 52000 + 2000 * k;
                hi = od ? 10000 : 70000;
            end
            3: begin
                v  = 2750 + 2500 * (k - 5);
                lo = 2750;
                hi = 25250;
            end
            default: v = (k < 6) ? 500 : 1000;
        endcase
        if (v < lo) v = lo;
        if (v > hi) v = hi;
        return 20'(v);
    endfunction : tv

    // Verdict and end of run
    task automatic complete_run();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    // One APB transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [`WPA_ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clock);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge i_clock);
            if (pready === 1'b1) break;
        end
        rd  = prdata;
        err = pslverr;
        if (n == 20) begin
            bad_count++;
            complete_run();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Note the expected answers, then let the host send the command
    task automatic cmd(input logic [7:0] b, input logic ok);
        exp_ack.push_back(ok);
        exp_ack.push_back(ok);
        if (ok) begin
            model = upd(model, b);
            exp_q.push_back(model);
        end
        host.send(b, $urandom_range(0, 3));
        repeat (2) @(posedge i_clock);
    endtask : cmd

    // Select a speed and compare every generator setting
    task automatic chk_time(input logic od);
        apb(1'b1, `WPA_REG_CTRL, {31'h0, od});
        repeat (2) @(negedge i_clock);
        `CHK(o_timing.reset_low_time, tv(0, od, od ? model.rstl_od : model.rstl_std))
        `CHK(o_timing.presence_sample_time, tv(1, od, od ? model.msp_od : model.msp_std))
        `CHK(o_timing.write_zero_low_time, tv(2, od, od ? model.wol_od : model.wol_std))
        `CHK(o_timing.write_zero_recovery_time, tv(3, od, model.rec0))
        `CHK({9'h0, o_timing.weak_pullup_resistance}, tv(4, od, model.wpu))
    endtask : chk_time

    // Result watcher: pairs each acknowledge and pointer load with the oldest note
    always @(negedge i_clock) begin
        if (i_byte.valid === 1'b1) begin
            ea = (exp_ack.size() > 0) ? exp_ack.pop_front() : 1'bx;
            `CHK(o_byte_ack, ea)
        end
        if (o_ptr_load === 1'b1) begin
            ec = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
            `CHK(o_codes, ec)
            `CHK(o_ptr_code, `WPA_PTR_PORT_CFG)
        end
    end

    // Cuts a hung run short
    initial begin
        repeat (60000) @(posedge i_clock);
        bad_count++;
        complete_run();
    end

    // Main sequence
    initial begin
        logic [7:0] b;
        void'($urandom(21));
        defs = {`WPA_DEF_RSTL, `WPA_DEF_RSTL, `WPA_DEF_MSP_OD, `WPA_DEF_MSP_STD,
                `WPA_DEF_WOL, `WPA_DEF_WOL, `WPA_DEF_REC0, `WPA_DEF_WPU};
        model     = defs;
        i_reset_n = 1'b0;
        busy      = 1'b0;
        dev_rst   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = '0;
        pwdata    = '0;
        repeat (6) @(posedge i_clock);
        i_reset_n <= 1'b1;
        apb(1'b0, `WPA_REG_CODES, 32'h0);
        `CHK(rd, defs)
        chk_time(1'b0);
        chk_time(1'b1);
        // Every select and speed flag with every value code
        for (int c = 0; c < 16; c++) begin
            for (int s = 0; s < 10; s++) begin
                cmd({3'(s / 2), 1'(s % 2), 4'(c)}, 1'b1);
            end
            chk_time(1'b0);
            chk_time(1'b1);
        end
        repeat (24) begin
            b      = 8'($urandom);
            b[7:5] = 3'($urandom_range(0, 4));
            cmd(b, 1'b1);
        end
        cmd(8'hE5, 1'b1); // Unused select stores nothing
        apb(1'b0, `WPA_REG_CODES, 32'h0);
        `CHK(rd, model)
        // Busy wire bus: both bytes refused, nothing stored
        busy <= 1'b1;
        cmd(8'h0F, 1'b0);
        `CHK(o_codes, model)
        apb(1'b0, `WPA_REG_STATUS, 32'h0);
        `CHK(rd[4:0], 5'h13)
        busy <= 1'b0;
        cmd(8'h65, 1'b1);
        dev_rst <= 1'b1;
        @(posedge i_clock);
        dev_rst <= 1'b0;
        @(negedge i_clock);
        `CHK(o_codes, defs)
        model = defs;
        cmd(8'h9A, 1'b1);
        apb(1'b1, `WPA_REG_CTRL, 32'h3);
        apb(1'b0, `WPA_REG_CTRL, 32'h0);
        `CHK(rd, 32'h1) // Restore bit reads back as zero
        `CHK(o_codes, defs)
        model = defs;
        // Unmapped and read-only places
        apb(1'b1, 5'h1C, 32'hFFFFFFFF);
        `CHK(err, 1'b1)
        apb(1'b0, 5'h0C, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, `WPA_REG_CODES, 32'h0);
        `CHK(o_codes, model)
        // Reset again in mid-run
        cmd(8'h0A, 1'b1);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_reset_n <= 1'b1;
        model = defs;
        `CHK(o_codes, defs)
        cmd(8'h3F, 1'b1);
        chk_time(1'b1);
        `CHK(exp_q.size(), 0)
        complete_run();
    end
endmodule : tb

// [testbench/wpa_host_model.sv]
// Host-side model that sends port-adjust commands over the byte link
`include "wpa_consts.svh"
module wpa_host_model
    import wpa_pkg::*;
(
    // Clock
    input  wire logic i_clock,
    // Byte link toward the block
    output wpa_byte_t o_byte,
    output logic      o_ack_rise
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle link at time zero
    initial begin
        o_byte     = '0;
        o_ack_rise = 1'b0;
    end

    // Code byte, control byte, optional stall, then the control acknowledge edge
    task automatic send(input logic [7:0] ctrl, input int gap);
        @(posedge i_clock);
        o_byte <= '{1'b1, 1'b1, `WPA_CMD_ADJUST};
        @(posedge i_clock);
        o_byte <= '{1'b1, 1'b0, ctrl};
        @(posedge i_clock);
        o_byte <= '{1'b0, 1'b0, ~ctrl}; // Released data shows the inverse
        repeat (gap) @(posedge i_clock);
        o_ack_rise <= 1'b1;
        @(posedge i_clock);
        o_ack_rise <= 1'b0;
    endtask : send
endmodule : wpa_host_model

// [verilog/wpa_consts.svh]
// Constants for the single-wire port parameter adjust block
`ifndef WPA_CONSTS_SVH
`define WPA_CONSTS_SVH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define WPA_CMD_ADJUST        8'hC3
`define WPA_PTR_PORT_CFG      8'hB4

// ----------------------------------------------------------------------------
// Control byte fields
// ----------------------------------------------------------------------------
`define WPA_SEL_MSB           7
`define WPA_SEL_LSB           5
`define WPA_OD_BIT            4
`define WPA_VAL_MSB           3
`define WPA_VAL_LSB           0

// ----------------------------------------------------------------------------
// Parameter select codes
// ----------------------------------------------------------------------------
`define WPA_SEL_RSTL          3'h0
`define WPA_SEL_MSP           3'h1
`define WPA_SEL_WOL           3'h2
`define WPA_SEL_REC0          3'h3
`define WPA_SEL_WPU           3'h4

// ----------------------------------------------------------------------------
// Default value codes
// ----------------------------------------------------------------------------
`define WPA_DEF_RSTL          4'h6
`define WPA_DEF_MSP_STD       4'h6
`define WPA_DEF_MSP_OD        4'h6
`define WPA_DEF_WOL           4'h6
`define WPA_DEF_REC0          4'h6
`define WPA_DEF_WPU           4'h6

// ----------------------------------------------------------------------------
// APB register offsets and fields
// ----------------------------------------------------------------------------
`define WPA_ADDR_W            5
`define WPA_REG_CTRL          5'h00
`define WPA_REG_CODES         5'h04
`define WPA_REG_STATUS        5'h08
`define WPA_CTRL_SPEED_BIT    0
`define WPA_CTRL_RESTORE_BIT  1

`endif

// [verilog/wpa_pkg.sv]
// Types for the single-wire port parameter adjust block
package wpa_pkg;

    // Byte handed over by the serial host front end
    typedef struct packed {
        logic       valid;      // One-cycle strobe per received byte
        logic       first;      // Byte is a command code
        logic [7:0] data;
    } wpa_byte_t;

    // Stored value codes, standard and overdrive sets
    typedef struct packed {
        logic [3:0] rstl_od;
        logic [3:0] rstl_std;
        logic [3:0] msp_od;
        logic [3:0] msp_std;
        logic [3:0] wol_od;
        logic [3:0] wol_std;
        logic [3:0] rec0;
        logic [3:0] wpu;
    } wpa_codes_t;

    // Settings for the waveform generator at the current speed
    typedef struct packed {
        logic [19:0] reset_low_time;
        logic [19:0] presence_sample_time;
        logic [19:0] write_zero_low_time;
        logic [19:0] write_zero_recovery_time;
        logic [10:0] weak_pullup_resistance;
    } wpa_timing_t;

    // Command handler states
    typedef enum logic [2:0] {
        WPA_IDLE   = 3'b001,
        WPA_PARAM  = 3'b010,
        WPA_REJECT = 3'b100
    } wpa_state_t;

endpackage : wpa_pkg

// [verilog/wpa_port_adjust.sv]
// Port-adjust command handler, parameter store and value tables
`include "wpa_consts.svh"

// Notes on behaviour
// - Code C3h plus control byte updates parameter
// - Busy at code: nack both, change nothing
// - Store on rising SCL of control ack
// - Then point read pointer at port config
// - Reset or device reset restores all defaults
// - Byte: select 7:5, speed 4, code 3:0
// - Select 0..4: rstl, msp, wol, rec0, pullup
// - Speed flag picks standard or overdrive copy
// - Recovery and pullup ignore the speed flag
// - Reset low 440..740 us, overdrive tenth
// - Presence std 58, +2 us, 76 cap
// - Presence od 5.5, +0.5 us, 11 cap
// - Write-zero low 52..70, od 5..10
// - Recovery 2.75, +2.5 us to 25.25
// - Pullup 500 below code 6, else 1000
// - Generator follows stored settings a cycle later, zero in reset
module wpa_port_adjust
    import wpa_pkg::*;
(
    // Clock and reset
    input  wire logic                    i_clock,
    input  wire logic                    i_reset_n,
    // Serial host front end
    input  wire wpa_byte_t               i_byte,
    input  wire logic                    i_ack_rise,
    output logic                         o_byte_ack,
    output logic                         o_ptr_load,
    output logic [7:0]                   o_ptr_code,
    // Device state
    input  wire logic                    i_wire_busy_flag,
    input  wire logic                    i_device_reset,
    // Waveform generator settings
    output wpa_timing_t                  o_timing,
    output wpa_codes_t                   o_codes,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`WPA_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr
);

    // ------------------------------------------------------------------------
    // Value tables
    // ------------------------------------------------------------------------
    function automatic logic [19:0] f_rstl(input logic [3:0] c, input logic od);
        int v;
        v = 440000 + 20000 * int'(c);
        if (od) begin
            v = v / 10;
        end
        return 20'(v);
    endfunction : f_rstl

    function automatic logic [19:0] f_msp(input logic [3:0] c, input logic od);
        int v;
        v = (c < 4'h2) ? 0 : int'(c) - 1;
        if (od) begin
            v = 5500 + 500 * v;
            v = (v > 11000) ? 11000 : v;
        end else begin
            v = 58000 + 2000 * v;
            v = (v > 76000) ? 76000 : v;
        end
        return 20'(v);
    endfunction : f_msp

    function automatic logic [19:0] f_wol(input logic [3:0] c, input logic od);
        int v;
        if (od) begin
            v = 5000 + 500 * int'(c);
            v = (v > 10000) ? 10000 : v;
        end else begin
            v = 52000 + 2000 * int'(c);
            v = (v > 70000) ? 70000 : v;
        end
        return 20'(v);
    endfunction : f_wol

    function automatic logic [19:0] f_rec0(input logic [3:0] c);
        int v;
        v = (c < 4'h6) ? 2750 : 2750 + 2500 * (int'(c) - 5);
        v = (v > 25250) ? 25250 : v;
        return 20'(v);
    endfunction : f_rec0

    function automatic logic [10:0] f_wpu(input logic [3:0] c);
        return (c < 4'h6) ? 11'h1F4 : 11'h3E8;
    endfunction : f_wpu

    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    wpa_state_t  state_q;
    wpa_codes_t  codes_q;
    logic [7:0]  ctrl_byte_q;
    logic        speed_q;
    logic        rejected_q;
    logic        restore_d;
    logic        is_adjust;
    logic        apb_wr;
    logic        store;
    logic [2:0]  sel;
    logic        od;
    logic [3:0]  val;

    // Control byte fields
    assign sel = ctrl_byte_q[`WPA_SEL_MSB:`WPA_SEL_LSB];
    assign od  = ctrl_byte_q[`WPA_OD_BIT];
    assign val = ctrl_byte_q[`WPA_VAL_MSB:`WPA_VAL_LSB];

    assign is_adjust = i_byte.valid && i_byte.first && (i_byte.data == `WPA_CMD_ADJUST);
    assign store     = (state_q == WPA_PARAM) && i_ack_rise;
    assign apb_wr    = psel && penable && pwrite && (paddr == `WPA_REG_CTRL);
    assign restore_d = i_device_reset || (apb_wr && pwdata[`WPA_CTRL_RESTORE_BIT]);

    // ------------------------------------------------------------------------
    // Command sequencing
    // ------------------------------------------------------------------------
    // Track command code, control byte and its acknowledge
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q     <= WPA_IDLE;
            ctrl_byte_q <= 8'h00;
        end else begin
            case (state_q)
                WPA_IDLE: begin
                    if (is_adjust) begin
                        state_q <= i_wire_busy_flag ? WPA_REJECT : WPA_PARAM;
                    end
                end
                WPA_PARAM: begin
                    if (i_byte.valid && i_byte.first) begin
                        state_q <= WPA_IDLE;                        // Aborted by a new command
                    end else if (i_byte.valid) begin
                        ctrl_byte_q <= i_byte.data;
                    end else if (i_ack_rise) begin
                        state_q <= WPA_IDLE;
                    end
                end
                WPA_REJECT: begin
                    if (is_adjust) begin
                        state_q <= i_wire_busy_flag ? WPA_REJECT : WPA_PARAM;
                    end else if ((i_byte.valid && i_byte.first) || i_ack_rise) begin
                        state_q <= WPA_IDLE;
                    end
                end
                default: begin
                    state_q <= WPA_IDLE;
                end
            endcase
        end
    end

    // Acknowledge: code only when idle bus, control byte only in accepted command
    always_comb begin
        o_byte_ack = 1'b0;
        if (is_adjust && (state_q != WPA_PARAM)) begin
            o_byte_ack = !i_wire_busy_flag;
        end else if (i_byte.valid && !i_byte.first && (state_q == WPA_PARAM)) begin
            o_byte_ack = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Parameter store
    // ------------------------------------------------------------------------
    // Update the selected code, restore defaults on reset
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            codes_q <= '{`WPA_DEF_RSTL, `WPA_DEF_RSTL, `WPA_DEF_MSP_OD, `WPA_DEF_MSP_STD,
                         `WPA_DEF_WOL, `WPA_DEF_WOL, `WPA_DEF_REC0, `WPA_DEF_WPU};
        end else if (restore_d) begin
            codes_q <= '{`WPA_DEF_RSTL, `WPA_DEF_RSTL, `WPA_DEF_MSP_OD, `WPA_DEF_MSP_STD,
                         `WPA_DEF_WOL, `WPA_DEF_WOL, `WPA_DEF_REC0, `WPA_DEF_WPU};
        end else if (store) begin
            case (sel)
                `WPA_SEL_RSTL: begin
                    if (od) codes_q.rstl_od <= val;
                    else    codes_q.rstl_std <= val;
                end
                `WPA_SEL_MSP: begin
                    if (od) codes_q.msp_od <= val;
                    else    codes_q.msp_std <= val;
                end
                `WPA_SEL_WOL: begin
                    if (od) codes_q.wol_od <= val;
                    else    codes_q.wol_std <= val;
                end
                `WPA_SEL_REC0: codes_q.rec0 <= val;
                `WPA_SEL_WPU:  codes_q.wpu  <= val;
                default: begin
                end
            endcase
        end
    end

    // Read pointer moves to port configuration after a stored command
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ptr_load <= 1'b0;
            o_ptr_code <= 8'h00;
        end else begin
            o_ptr_load <= store;
            if (store) begin
                o_ptr_code <= `WPA_PTR_PORT_CFG;
            end
        end
    end

    // Generator settings for the current speed
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_timing <= '0;
        end else begin
            o_timing.reset_low_time <=
                f_rstl(speed_q ? codes_q.rstl_od : codes_q.rstl_std, speed_q);
            o_timing.presence_sample_time <=
                f_msp(speed_q ? codes_q.msp_od : codes_q.msp_std, speed_q);
            o_timing.write_zero_low_time <=
                f_wol(speed_q ? codes_q.wol_od : codes_q.wol_std, speed_q);
            o_timing.write_zero_recovery_time <= f_rec0(codes_q.rec0);
            o_timing.weak_pullup_resistance   <= f_wpu(codes_q.wpu);
        end
    end
    assign o_codes = codes_q;

    // ------------------------------------------------------------------------
    // APB registers
    // ------------------------------------------------------------------------
    // Control register: current bus speed
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            speed_q <= 1'b0;
        end else if (apb_wr) begin
            speed_q <= pwdata[`WPA_CTRL_SPEED_BIT];
        end
    end

    // Last command outcome
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rejected_q <= 1'b0;
        end else if (is_adjust && (state_q != WPA_PARAM)) begin
            rejected_q <= i_wire_busy_flag;
        end
    end

    // Read mux and error answer
    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        case (paddr)
            `WPA_REG_CTRL:   prdata = {31'h0000_0000, speed_q};
            `WPA_REG_CODES:  prdata = codes_q;
            `WPA_REG_STATUS: prdata = {27'h000_0000, rejected_q, state_q, i_wire_busy_flag};
            default:         pslverr = psel && penable;
        endcase
    end
    assign pready = 1'b1;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    sequence s_accept;
        is_adjust && !i_wire_busy_flag && (state_q == WPA_IDLE);
    endsequence
    sequence s_ctrl_byte;
        i_byte.valid && !i_byte.first;
    endsequence

    property p_busy_nack;
        is_adjust && i_wire_busy_flag && (state_q == WPA_IDLE) |-> !o_byte_ack;
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("busy code acked");

    property p_reject_stable;
        (state_q == WPA_REJECT) && !restore_d |=> $stable(codes_q) && !o_ptr_load;
    endproperty
    a_reject_stable: assert property (p_reject_stable) else $error("rejected cmd stored");

    property p_accept_flow;
        s_accept ##1 s_ctrl_byte |-> o_byte_ack;
    endproperty
    a_accept_flow: assert property (p_accept_flow) else $error("control byte nacked");

    property p_ptr_after_store;
        store |=> o_ptr_load && (o_ptr_code == 8'hB4) ##1 !o_ptr_load;
    endproperty
    a_ptr_after_store: assert property (p_ptr_after_store) else $error("pointer not set");

    property p_store_value;
        store && !restore_d && (sel == 3'h0) && od |=>
            (codes_q.rstl_od == $past(val)) && $stable(codes_q.rstl_std);
    endproperty
    a_store_value: assert property (p_store_value) else $error("wrong copy stored");

    property p_rec_no_od;
        store && !restore_d && (sel == 3'h3) |=> codes_q.rec0 == $past(val);
    endproperty
    a_rec_no_od: assert property (p_rec_no_od) else $error("recovery not stored");

    property p_restore;
        restore_d |=> codes_q.wpu == `WPA_DEF_WPU && codes_q.rec0 == `WPA_DEF_REC0;
    endproperty
    a_restore: assert property (p_restore) else $error("defaults not restored");

    property p_rstl_table;
        !speed_q && $stable(speed_q) |=>
            o_timing.reset_low_time == 20'(440000 + 20000 * int'($past(codes_q.rstl_std)));
    endproperty
    a_rstl_table: assert property (p_rstl_table) else $error("reset low value wrong");

    property p_wpu_table;
        1'b1 |=> o_timing.weak_pullup_resistance ==
            (($past(codes_q.wpu) < 4'h6) ? 11'h1F4 : 11'h3E8);
    endproperty
    a_wpu_table: assert property (p_wpu_table) else $error("pullup value wrong");

    property p_no_store_idle;
        (state_q == WPA_IDLE) && !restore_d |=> $stable(codes_q);
    endproperty
    a_no_store_idle: assert property (p_no_store_idle) else $error("stray store");

    property p_reject_entry;
        is_adjust && i_wire_busy_flag && (state_q != WPA_PARAM) |=> (state_q == WPA_REJECT);
    endproperty
    a_reject_entry: assert property (p_reject_entry) else $error("busy code not rejected");

    property p_rec_floor;
        (codes_q.rec0 < 4'h6) |=> (o_timing.write_zero_recovery_time == 20'h00ABE);
    endproperty
    a_rec_floor: assert property (p_rec_floor) else $error("recovery floor wrong");

endmodule : wpa_port_adjust

// [verilog/wpa_unused_guard.sv]
// Intentionally empty: all logic lives in the port-adjust module
